// File: rtl/borpt_pkg.sv
// Package of constants and types for the brown-out reset and power-up timer block.
package borpt_pkg;
    // Register map on the Avalon-MM slave (word offsets are byte addresses).
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam logic [3:0] CFG_ADDR = 4'h8;
    // Field positions in the control register.
    localparam int SOFT_EN_BIT = 6;
    localparam int POR_FLAG_BIT = 1;
    localparam int BOR_FLAG_BIT = 0;
    // Reset values.
    localparam logic [1:0] MODE_RST = 2'h3;
    localparam logic [1:0] THRESH_RST = 2'h0;
    localparam logic POWER_UP_TIMER_EN_N_RST = 1'h0;
    // Timing: the slow oscillator period and the counts derived from it at 20 MHz.
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOW_PERIOD_NS = 32000;
    localparam int SLOW_DIV = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int POWER_UP_TIMER_PERIODS = 2048;
    localparam int POWER_UP_TIMER_WIDTH = 11;
    localparam int BOR_MIN_NS = 200000;
    localparam int BOR_MIN_TICKS = (BOR_MIN_NS + SLOW_PERIOD_NS - 1) / SLOW_PERIOD_NS;
    localparam int OST_CYCLES = 1024;
    localparam int OST_WIDTH = 10;
    // Brown-out mode field encodings.
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_SOFT = 2'b01,
        MODE_NOSLEEP = 2'b10,
        MODE_ON = 2'b11
    } borpt_mode_t;
    // Reset sequencer states.
    typedef enum logic [1:0] {
        ST_BOR = 2'b00,
        ST_POWER_UP_TIMER = 2'b01,
        ST_OST = 2'b10,
        ST_RUN = 2'b11
    } borpt_state_t;
endpackage

// File: rtl/borpt_sync_if.sv
// Interface carrying the slow tick and qualified comparator level between modules.
`timescale 1ns/100ps
interface borpt_sync_if;
    logic slow_tick;
    logic below_q;
    modport src (output slow_tick, output below_q);
    modport dst (input slow_tick, input below_q);
endinterface

// File: rtl/borpt_slow_sync.sv
// Slow oscillator tick divider and comparator synchroniser.
`timescale 1ns/100ps
module borpt_slow_sync (
    input wire logic core_clk_i, // core clock
    input wire logic rst_i, // synchronous reset
    input wire logic below_i, // raw comparator level
    borpt_sync_if.src sy // tick and synchronised level
);
    typedef struct packed {
        logic [9:0] div;
        logic tick;
        logic s1;
        logic s2;
        logic below;
    } borpt_ss_t;
    borpt_ss_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.div == 10'(borpt_pkg::SLOW_DIV - 1)) begin
            st_nxt.div = 10'h000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 10'h001;
        end
        st_nxt.s1 = below_i;
        st_nxt.s2 = st_r.s1;
        // The comparator is sampled into the slow domain on each tick.
        if (st_r.tick) begin
            st_nxt.below = st_r.s2;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sy.slow_tick = st_r.tick;
    assign sy.below_q = st_r.below;
endmodule // borpt_slow_sync

// File: rtl/borpt_top.sv
// Brown-out reset control and power-up timer with Avalon-MM register access.
// Summary of operation
// - Detection possible for every mode except 00.
// - Sustained dip beyond minimum duration asserts reset.
// - Reset holds while supply stays below threshold.
// - Power-up timer starts after supply recovers.
// - Dip during timing restarts brown-out and timer.
// - Brown-out and timer enables are independent.
// - Mode 01 uses software enable bit six.
// - Other modes ignore soft enable, read 0.
// - Threshold only from configuration select bits.
// - Brown-out flag cleared on brown-out/power-on; a same-cycle software set wins if the flag was clear.
// - Mode 10 disables detection during Sleep.
// - Mode 00 keeps detection disabled.
// - Mode 11 keeps detection always enabled.
// - Timer counts 2048 slow oscillator periods.
// - Reset held while timer counts.
// - Timer runs when enable-low bit clear.
// - Oscillator start-up delay follows in crystal modes; with the timer disabled, only while the power-on flag is clear.
// - Soft enable resets to 1 in mode 01.
// - Power-on flag cleared only by power-on.
`timescale 1ns/100ps
module borpt_top (
    input wire logic core_clk_i, // 20 MHz clock
    input wire logic rst_i, // power-on reset, synchronous, active high
    input wire logic below_thresh_i, // comparator: supply below threshold
    input wire logic sleep_i, // device is in Sleep
    input wire logic crystal_mode_i, // crystal oscillator mode selected
    input wire logic osc_clk_en_i, // one pulse per main oscillator cycle
    input wire logic [3:0] avs_address_i, // Avalon byte address
    input wire logic avs_read_i, // Avalon read
    input wire logic avs_write_i, // Avalon write
    input wire logic [31:0] avs_writedata_i, // Avalon write data
    input wire logic [3:0] avs_byteenable_i, // Avalon byte enables
    output logic [31:0] avs_readdata_o, // Avalon read data
    output logic avs_waitrequest_o, // Avalon wait request
    output logic [1:0] avs_response_o, // Avalon response
    output logic reset_req_o, // internal reset request
    output logic [1:0] brown_out_threshold_select_o // threshold to comparator
);
    typedef struct packed {
        borpt_pkg::borpt_state_t state;
        logic [1:0] mode;
        logic [1:0] thresh;
        logic power_up_timer_en_n;
        logic soft_en;
        logic por_flag;
        logic bor_flag;
        logic [borpt_pkg::POWER_UP_TIMER_WIDTH-1:0] power_up_timer_cnt;
        logic [3:0] dip_cnt;
        logic [borpt_pkg::OST_WIDTH-1:0] ost_cnt;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic rst_req;
    } borpt_st_t;
    borpt_st_t st_r, st_nxt;

    borpt_sync_if sy ();

    borpt_slow_sync u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .below_i(below_thresh_i),
        .sy(sy)
    );

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == borpt_pkg::CTRL_ADDR) || (a == borpt_pkg::STAT_ADDR)
            || (a == borpt_pkg::CFG_ADDR);
    endfunction

    logic det_en;
    logic soft_vis;
    logic dip_long;

    always_comb begin
        soft_vis = (st_r.mode == borpt_pkg::MODE_SOFT) && st_r.soft_en;
        unique case (st_r.mode)
            borpt_pkg::MODE_OFF: det_en = 1'b0;
            borpt_pkg::MODE_SOFT: det_en = st_r.soft_en;
            borpt_pkg::MODE_NOSLEEP: det_en = !sleep_i;
            borpt_pkg::MODE_ON: det_en = 1'b1;
            default: det_en = 1'b0;
        endcase
        dip_long = (st_r.dip_cnt >= 4'(borpt_pkg::BOR_MIN_TICKS));
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        // Minimum-duration filter on the synchronised comparator level.
        if (!sy.below_q || !det_en) begin
            st_nxt.dip_cnt = 4'h0;
        end else if (sy.slow_tick && !dip_long) begin
            st_nxt.dip_cnt = st_r.dip_cnt + 4'h1;
        end
        case (st_r.state)
            borpt_pkg::ST_BOR: begin
                st_nxt.power_up_timer_cnt = '0;
                if (!sy.below_q || !det_en) begin
                    if (!st_r.power_up_timer_en_n) begin
                        st_nxt.state = borpt_pkg::ST_POWER_UP_TIMER;
                    end else if (st_r.por_flag == 1'b0 && crystal_mode_i) begin
                        st_nxt.state = borpt_pkg::ST_OST;
                    end else begin
                        st_nxt.state = borpt_pkg::ST_RUN;
                    end
                end
            end
            borpt_pkg::ST_POWER_UP_TIMER: begin
                if (det_en && dip_long) begin
                    st_nxt.state = borpt_pkg::ST_BOR;
                    st_nxt.power_up_timer_cnt = '0;
                    st_nxt.bor_flag = 1'b0;
                end else if (sy.slow_tick) begin
                    st_nxt.power_up_timer_cnt = st_r.power_up_timer_cnt + 11'h001;
                    if (st_r.power_up_timer_cnt == 11'(borpt_pkg::POWER_UP_TIMER_PERIODS - 1)) begin
                        st_nxt.state = crystal_mode_i ? borpt_pkg::ST_OST
                                                      : borpt_pkg::ST_RUN;
                    end
                end
            end
            borpt_pkg::ST_OST: begin
                if (det_en && dip_long) begin
                    st_nxt.state = borpt_pkg::ST_BOR;
                    st_nxt.bor_flag = 1'b0;
                    st_nxt.ost_cnt = '0;
                end else if (osc_clk_en_i) begin
                    st_nxt.ost_cnt = st_r.ost_cnt + 10'h001;
                    if (st_r.ost_cnt == 10'(borpt_pkg::OST_CYCLES - 1)) begin
                        st_nxt.state = borpt_pkg::ST_RUN;
                    end
                end
            end
            borpt_pkg::ST_RUN: begin
                st_nxt.ost_cnt = '0;
                if (det_en && dip_long) begin
                    st_nxt.state = borpt_pkg::ST_BOR;
                    st_nxt.bor_flag = 1'b0;
                end
            end
            default: st_nxt.state = borpt_pkg::ST_BOR;
        endcase
        st_nxt.rst_req = (st_nxt.state != borpt_pkg::ST_RUN);
        // Avalon slave: one wait cycle, then ack with data.
        if ((avs_read_i || avs_write_i) && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.resp = mapped(avs_address_i) ? 2'h0 : 2'h2;
            st_nxt.rdata = 32'h0000_0000;
            if (avs_read_i) begin
                case (avs_address_i)
                    borpt_pkg::CTRL_ADDR: begin
                        st_nxt.rdata[borpt_pkg::SOFT_EN_BIT] = soft_vis;
                        st_nxt.rdata[borpt_pkg::POR_FLAG_BIT] = st_r.por_flag;
                        st_nxt.rdata[borpt_pkg::BOR_FLAG_BIT] = st_r.bor_flag;
                    end
                    borpt_pkg::STAT_ADDR: begin
                        st_nxt.rdata[1:0] = st_r.state;
                        st_nxt.rdata[2] = st_r.rst_req;
                        st_nxt.rdata[3] = det_en;
                        st_nxt.rdata[14:4] = st_r.power_up_timer_cnt;
                    end
                    borpt_pkg::CFG_ADDR: begin
                        st_nxt.rdata[1:0] = st_r.mode;
                        st_nxt.rdata[3:2] = st_r.thresh;
                        st_nxt.rdata[4] = st_r.power_up_timer_en_n;
                    end
                    default: st_nxt.rdata = 32'h0000_0000;
                endcase
            end else if (avs_byteenable_i[0]) begin
                if (avs_address_i == borpt_pkg::CTRL_ADDR) begin
                    if (st_r.mode == borpt_pkg::MODE_SOFT) begin
                        st_nxt.soft_en = avs_writedata_i[borpt_pkg::SOFT_EN_BIT];
                    end
                    // Flags: software may only set; a same-cycle hardware clear wins only if bor_flag was set.
                    if (avs_writedata_i[borpt_pkg::POR_FLAG_BIT]) begin
                        st_nxt.por_flag = 1'b1;
                    end
                    if (avs_writedata_i[borpt_pkg::BOR_FLAG_BIT]
                        && st_nxt.bor_flag == st_r.bor_flag) begin
                        st_nxt.bor_flag = 1'b1;
                    end
                end else if (avs_address_i == borpt_pkg::CFG_ADDR) begin
                    // Configuration bits, as if reprogrammed; threshold is set only here.
                    st_nxt.mode = avs_writedata_i[1:0];
                    st_nxt.thresh = avs_writedata_i[3:2];
                    st_nxt.power_up_timer_en_n = avs_writedata_i[4];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.state <= borpt_pkg::ST_BOR;
            st_r.mode <= borpt_pkg::MODE_RST;
            st_r.thresh <= borpt_pkg::THRESH_RST;
            st_r.power_up_timer_en_n <= borpt_pkg::POWER_UP_TIMER_EN_N_RST;
            st_r.soft_en <= 1'b1;
            st_r.por_flag <= 1'b0;
            st_r.bor_flag <= 1'b0;
            st_r.rst_req <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        avs_readdata_o = st_r.rdata;
        avs_waitrequest_o = !st_r.ack;
        avs_response_o = st_r.resp;
        reset_req_o = st_r.rst_req;
        brown_out_threshold_select_o = st_r.thresh;
    end
endmodule // borpt_top

// File: tb/borpt_top_monitor.sv
// Checker of bus timing and brown-out behaviour at the top ports.
`timescale 1ns/100ps
module borpt_top_monitor (
    input wire logic core_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic below_thresh_i, // comparator
    input wire logic sleep_i, // sleep
    input wire logic [3:0] avs_address_i, // address
    input wire logic avs_read_i, // read
    input wire logic avs_write_i, // write
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte enables
    input wire logic [31:0] avs_readdata_o, // read data
    input wire logic avs_waitrequest_o, // wait
    input wire logic [1:0] avs_response_o, // response
    input wire logic reset_req_o, // reset request
    input wire logic [1:0] brown_out_threshold_select_o // threshold
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] mode_r;
    logic soft_r;
    logic [12:0] dip_r;
    logic wr, det, map;
    assign wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign det = mode_r == 2'h3 || (mode_r == 2'h2 && !sleep_i) || (mode_r == 2'h1 && soft_r);
    assign map = avs_address_i inside {4'h0, 4'h4, 4'h8};
    // Shadow of mode and soft enable, and a count of cycles spent below while detecting.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_r <= 2'h3;
            soft_r <= 1'h1;
            dip_r <= 13'h0000;
        end else begin
            if (wr && avs_address_i == borpt_pkg::CFG_ADDR) mode_r <= avs_writedata_i[1:0];
            if (wr && avs_address_i == borpt_pkg::CTRL_ADDR && mode_r == 2'h1) soft_r <= avs_writedata_i[6];
            dip_r <= !(below_thresh_i && det) ? 13'h0000 : (dip_r == 13'h16a8 ? dip_r : dip_r + 13'h0001);
        end
    end
    property p_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered next cycle");
    property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_one: assert property (p_one)
        else $error("answer longer than one cycle");
    property p_resp; !avs_waitrequest_o |-> avs_response_o == (map ? 2'h0 : 2'h2); endproperty
    a_resp: assert property (p_resp)
        else $error("wrong response code");
    property p_soft; !avs_waitrequest_o && avs_read_i && avs_address_i == 4'h0 && mode_r != 2'h1 |-> !avs_readdata_o[6]; endproperty
    a_soft: assert property (p_soft)
        else $error("soft enable read as one outside mode 01");
    property p_por; $fell(rst_i) |-> reset_req_o; endproperty
    a_por: assert property (p_por)
        else $error("reset request low after power-on");
    property p_trip; dip_r == 13'h16a8 |-> reset_req_o; endproperty
    a_trip: assert property (p_trip)
        else $error("sustained dip did not reset");
    property p_hold; reset_req_o && below_thresh_i && det |=> reset_req_o; endproperty
    a_hold: assert property (p_hold)
        else $error("reset released while supply below");
    property p_off; mode_r == 2'h0 && !reset_req_o |=> !reset_req_o; endproperty
    a_off: assert property (p_off)
        else $error("reset raised with detection off");
    // The threshold flop updates at the edge that takes the write, so the change is
    // seen in the same cycle in which waitrequest is low for that write.
    property p_thr; $changed(brown_out_threshold_select_o) |-> wr && avs_address_i == 4'h8; endproperty
    a_thr: assert property (p_thr)
        else $error("threshold changed without a write");
endmodule // borpt_top_monitor
bind borpt_top borpt_top_monitor u_borpt_top_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .below_thresh_i(below_thresh_i), .sleep_i(sleep_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .reset_req_o(reset_req_o), .brown_out_threshold_select_o(brown_out_threshold_select_o));

// File: tb/borpt_supply_model.sv
// Model of the supply comparator and main oscillator seen by the block.
`timescale 1ns/100ps
module borpt_supply_model (
    input wire logic core_clk_i, // clock
    input wire logic [2:0] supply_i, // supply level step
    input wire logic [1:0] thresh_i, // threshold from the block
    output logic below_o, // supply at or below threshold
    output logic osc_en_o // oscillator pulse
);
    logic [1:0] div_r = 2'h0;
    always_ff @(posedge core_clk_i) begin
        below_o <= supply_i <= {1'h0, thresh_i};
        div_r <= div_r + 2'h1;
        osc_en_o <= div_r == 2'h3;
    end
endmodule // borpt_supply_model

// File: tb/borpt_tb_top.sv
// Self-checking bench of the brown-out reset and power-up timer block.
`timescale 1ns/100ps
module borpt_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic slp = 1'h0;
    logic xtal = 1'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [2:0] sup = 3'h7;
    logic [31:0] rdat, q;
    logic [1:0] resp, qr, thr;
    logic below, osc, req, wt;
    int error_cnt = 0;
    int tests_run = 0;
    always #25 clk = ~clk;
    borpt_top u_borpt_top (.core_clk_i(clk), .rst_i(rst), .below_thresh_i(below), .sleep_i(slp),
        .crystal_mode_i(xtal), .osc_clk_en_i(osc), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .avs_response_o(resp), .reset_req_o(req),
        .brown_out_threshold_select_o(thr));
    borpt_supply_model u_borpt_supply_model (.core_clk_i(clk), .supply_i(sup), .thresh_i(thr),
        .below_o(below), .osc_en_o(osc));
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wt === 1'h0) break;
        end
        q = rdat;
        qr = resp;
        rd <= 1'h0;
        wr <= 1'h0;
        if (n == 50) begin
            error_cnt++;
            $display("[FAIL] bus answer expected %h seen %h", 1'h0, wt);
            summarize();
        end
    endtask
    task automatic wait_st(input logic [1:0] s);
        int n;
        for (n = 0; n < 900; n++) begin
            bus(1'h0, borpt_pkg::STAT_ADDR, 32'h0000_0000);
            if (q[1:0] === s) break;
            repeat (8) @(posedge clk);
        end
        chk("state", s, q[1:0]);
        if (n == 900) summarize();
    endtask
    task automatic t_reset;
        bus(1'h0, borpt_pkg::CFG_ADDR, 32'h0000_0000);
        chk("cfg", 32'h0000_0003, q);
        bus(1'h0, borpt_pkg::CTRL_ADDR, 32'h0000_0000);
        chk("ctrl", 32'h0000_0000, q);
        bus(1'h0, borpt_pkg::STAT_ADDR, 32'h0000_0000);
        chk("stat req", 1, q[2]);
        bus(1'h0, 4'hc, 32'h0000_0000);
        chk("resp", 2, qr);
        chk("data", 0, q);
    endtask
    task automatic t_modes;
        logic [3:0] tb [6] = '{4'h0, 4'h6, 4'h4, 4'h8, 4'h9, 4'hd};
        bus(1'h1, borpt_pkg::CFG_ADDR, 32'h0000_0009);
        bus(1'h0, borpt_pkg::CTRL_ADDR, 32'h0000_0000);
        chk("soft rst", 1, q[6]);
        for (int i = 0; i < 6; i++) begin
            slp <= tb[i][0];
            bus(1'h1, borpt_pkg::CFG_ADDR, {28'h000_0000, 2'h2, tb[i][3:2]});
            if (tb[i][3:2] == 2'h1) bus(1'h1, 4'h0, {25'h000_0000, tb[i][1], 6'h00});
            repeat (4) @(posedge clk);
            bus(1'h0, borpt_pkg::STAT_ADDR, 32'h0000_0000);
            chk("detect", i % 2, q[3]);
            bus(1'h0, borpt_pkg::CTRL_ADDR, 32'h0000_0000);
            chk("soft", tb[i][1], q[6]);
        end
        slp <= 1'h0;
        bus(1'h1, borpt_pkg::CTRL_ADDR, 32'h0000_0040);
        chk("thresh", 2, thr);
    endtask
    task automatic t_dip;
        bus(1'h1, borpt_pkg::CFG_ADDR, 32'h0000_000b);
        bus(1'h1, borpt_pkg::CTRL_ADDR, 32'h0000_0003);
        sup <= 3'h1;
        wait_st(2'h0);
        chk("req", 1, req);
        bus(1'h0, borpt_pkg::CTRL_ADDR, 32'h0000_0000);
        chk("flags", 2, q[1:0]);
        repeat (3000) @(posedge clk);
        chk("held", 1, req);
        sup <= 3'h7;
        wait_st(2'h1);
        repeat (1300) @(posedge clk);
        bus(1'h0, borpt_pkg::STAT_ADDR, 32'h0000_0000);
        chk("counting", 1, q[14:4] != 11'h000 && req);
        sup <= 3'h2;
        wait_st(2'h0);
        bus(1'h1, borpt_pkg::CFG_ADDR, 32'h0000_001b);
        sup <= 3'h7;
        wait_st(2'h3);
        repeat (2) @(posedge clk);
        chk("released", 0, req);
    endtask
    task automatic t_off;
        bus(1'h1, borpt_pkg::CFG_ADDR, 32'h0000_0018);
        sup <= 3'h0;
        repeat (7000) @(posedge clk);
        chk("off", 0, req);
        sup <= 3'h7;
    endtask
    // A second power-on in crystal mode: with the timer disabled the start-up delay follows.
    task automatic t_ost;
        @(posedge clk);
        rst <= 1'h1;
        xtal <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        bus(1'h0, borpt_pkg::STAT_ADDR, 32'h0000_0000);
        chk("por req", 1, q[2]);
        bus(1'h1, borpt_pkg::CFG_ADDR, 32'h0000_001b);
        sup <= 3'h1;
        wait_st(2'h0);
        sup <= 3'h7;
        wait_st(2'h2);
        chk("ost req", 1, req);
        wait_st(2'h3);
        repeat (2) @(posedge clk);
        chk("ost done", 0, req);
        xtal <= 1'h0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_modes();
        t_dip();
        t_off();
        t_ost();
        summarize();
    end
endmodule // borpt_tb_top
